// >>> design/pbl_bist.sv
`timescale 1ns/1ns
`include "pbl_regs.svh"
module pbl_bist
    import pbl_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [15:0] i_reg_wdata,
    output logic [15:0]     o_reg_rdata,
    input  wire logic       i_gigabit,
    input  wire logic       i_mac_tx_valid,
    input  wire logic [7:0] i_mac_tx_data,
    input  wire logic       i_mac_tx_last,
    output logic            o_mac_tx_ready,
    output logic            o_mac_rx_dv,
    output logic [7:0]      o_mac_rx_data,
    output logic            o_line_tx_valid,
    output logic [7:0]      o_line_tx_data,
    output logic            o_line_tx_last,
    input  wire logic       i_line_tx_ready,
    input  wire logic       i_line_rx_dv,
    input  wire logic [7:0] i_line_rx_data,
    output logic [2:0]      o_loop_sel
);
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [15:0] next_rdata;
    logic [2:0]  next_loop_sel;
    pbl_loop_e   act_loop;
    logic        rd_stat;
    logic        rd_rx;
    logic        rd_err;
    logic        internal_loop;

    // loop selection, held in the self-test control register
    always_comb begin
        rd_stat = i_reg_rd && (i_reg_addr == `PBL_STAT_OFS);
        rd_rx   = i_reg_rd && (i_reg_addr == `PBL_RXCNT_OFS);
        rd_err  = i_reg_rd && (i_reg_addr == `PBL_ERRCNT_OFS);
        case (ctrl[`PBL_LOOP_MSB:`PBL_LOOP_LSB])
            3'h1:    act_loop = PBL_LOOP_DIGITAL;
            3'h2:    act_loop = PBL_LOOP_ANALOG;
            // the cable loop cannot carry gigabit signalling
            3'h3:    act_loop = i_gigabit ? PBL_LOOP_NONE : PBL_LOOP_EXTERNAL;
            3'h4:    act_loop = PBL_LOOP_REVERSE;
            default: act_loop = PBL_LOOP_NONE;
        endcase
        internal_loop = (act_loop == PBL_LOOP_DIGITAL) || (act_loop == PBL_LOOP_ANALOG);
        next_ctrl     = (i_reg_wr && i_reg_addr == `PBL_CTRL_OFS) ? i_reg_wdata : ctrl;
        next_loop_sel = act_loop;
    end

    // ---------------- generator ----------------
    pbl_gen_e    gen_state;
    pbl_gen_e    next_gen_state;
    pbl_lfsr_t   gen_lfsr;
    pbl_lfsr_t   next_gen_lfsr;
    logic [10:0] gen_cnt;
    logic [10:0] next_gen_cnt;
    logic [10:0] pkt_len;
    logic [10:0] gap_len;
    logic        gen_busy;
    logic        gen_push;
    logic        gen_last;
    logic        fifo_in_ready;
    pbl_lfsr_t   gen_step;

    always_comb begin
        pkt_len  = ctrl[`PBL_LONG_BIT] ? `PBL_LONG_LEN : `PBL_SHORT_LEN;
        gap_len  = (ctrl[`PBL_GAP_MSB:`PBL_GAP_LSB] == 5'h00) ? 11'd1
                 : {6'h00, ctrl[`PBL_GAP_MSB:`PBL_GAP_LSB]};
        gen_busy = gen_state != PBL_GEN_IDLE;
        gen_step = pbl_step8(gen_lfsr);
        gen_push = (gen_state == PBL_GEN_PKT) && fifo_in_ready;
        gen_last = gen_cnt == 11'(pkt_len - 11'd1);
        next_gen_state = gen_state;
        next_gen_cnt   = gen_cnt;
        // the register holds its value across gaps so the stream never restarts
        next_gen_lfsr  = gen_push ? gen_step : gen_lfsr;
        case (gen_state)
            PBL_GEN_IDLE: begin
                if (ctrl[`PBL_GEN_EN_BIT]) begin
                    next_gen_state = PBL_GEN_PKT;
                    next_gen_cnt   = 11'd0;
                end
            end
            PBL_GEN_PKT: begin
                if (gen_push) begin
                    next_gen_cnt   = gen_last ? 11'd0 : 11'(gen_cnt + 11'd1);
                    next_gen_state = gen_last ? PBL_GEN_GAP : PBL_GEN_PKT;
                end
            end
            PBL_GEN_GAP: begin
                next_gen_cnt = 11'(gen_cnt + 11'd1);
                if (gen_cnt == 11'(gap_len - 11'd1)) begin
                    next_gen_cnt   = 11'd0;
                    next_gen_state = ctrl[`PBL_GEN_EN_BIT] ? PBL_GEN_PKT : PBL_GEN_IDLE;
                end
            end
            default: next_gen_state = PBL_GEN_IDLE;
        endcase
    end

    // ---------------- transmit path into the FIFO ----------------
    logic       rh_valid;
    logic [7:0] rh_data;
    logic       next_rh_valid;
    logic [7:0] next_rh_data;
    logic       rev_push;
    logic [7:0] rev_data;
    logic       rev_last;
    logic       fifo_in_valid;
    logic [8:0] fifo_in_data;
    logic       fifo_out_valid;
    logic [8:0] fifo_out_data;
    logic       fifo_out_ready;
    logic       is_reverse;

    always_comb begin
        is_reverse = act_loop == PBL_LOOP_REVERSE;
        // one byte held back so the frame end can be marked on the last byte
        rev_push      = is_reverse && rh_valid;
        rev_data      = rh_data;
        rev_last      = !i_line_rx_dv;
        next_rh_valid = is_reverse && i_line_rx_dv;
        next_rh_data  = i_line_rx_dv ? i_line_rx_data : rh_data;
        if (gen_busy) begin
            fifo_in_valid = gen_state == PBL_GEN_PKT;
            fifo_in_data  = {gen_last, gen_step[7:0]};
        end else if (is_reverse) begin
            // the MAC transmit bus is not looked at in this mode
            fifo_in_valid = rev_push;
            fifo_in_data  = {rev_last, rev_data};
        end else begin
            fifo_in_valid = i_mac_tx_valid;
            fifo_in_data  = {i_mac_tx_last, i_mac_tx_data};
        end
        // an internal loop drains at once; the line is not allowed to stall it
        fifo_out_ready = internal_loop || i_line_tx_ready;
    end

    pbl_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (fifo_in_valid),
        .i_in_data   (fifo_in_data),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_out_ready)
    );

    // FIFO ready gated by gen_busy and is_reverse; only the plain MAC path may be offered
    assign o_mac_tx_ready  = fifo_in_ready && !gen_busy && !is_reverse;
    assign o_line_tx_valid = fifo_out_valid;
    assign o_line_tx_data  = fifo_out_data[7:0];
    assign o_line_tx_last  = fifo_out_data[8];

    // ---------------- checker ----------------
    pbl_chk_e    chk_state;
    pbl_chk_e    next_chk_state;
    pbl_lfsr_t   chk_lfsr;
    pbl_lfsr_t   next_chk_lfsr;
    pbl_lfsr_t   chk_step;
    logic [3:0]  chk_run;
    logic [3:0]  next_chk_run;
    logic        sync_lost;
    logic        next_sync_lost;
    logic [15:0] rx_cnt;
    logic [15:0] err_cnt;
    logic [15:0] next_rx_cnt;
    logic [15:0] next_err_cnt;
    logic        chk_valid;
    logic [7:0]  chk_data;
    logic        chk_match;
    logic        locked;

    function automatic logic [15:0] bump(input logic [15:0] v, input logic cont);
        if (v == `PBL_CNT_MAX) begin
            return cont ? 16'h0000 : v;
        end
        return 16'(v + 16'h0001);
    endfunction

    always_comb begin
        chk_valid = internal_loop ? (fifo_out_valid && fifo_out_ready) : i_line_rx_dv;
        chk_data  = internal_loop ? fifo_out_data[7:0] : i_line_rx_data;
        chk_step  = pbl_step8(chk_lfsr);
        chk_match = chk_step[7:0] == chk_data;
        locked    = chk_state == PBL_CHK_LOCK;
        next_chk_state = chk_state;
        next_chk_lfsr  = chk_lfsr;
        next_chk_run   = chk_run;
        next_sync_lost = sync_lost && !rd_stat;
        next_rx_cnt    = rd_rx ? 16'h0000 : rx_cnt;
        next_err_cnt   = rd_err ? 16'h0000 : err_cnt;
        if (!ctrl[`PBL_CHK_EN_BIT]) begin
            next_chk_state = PBL_CHK_HUNT;
            next_chk_run   = 4'h0;
        end else if (chk_valid) begin
            case (chk_state)
                PBL_CHK_HUNT: begin
                    // seed from the wire; two bytes cover the whole register
                    next_chk_lfsr = {chk_lfsr[6:0], chk_data};
                    next_chk_run  = chk_match ? 4'(chk_run + 4'h1) : 4'h0;
                    if (chk_match && chk_run == 4'(`PBL_LOCK_MATCHES - 4'h1)) begin
                        next_chk_state = PBL_CHK_LOCK;
                        next_chk_run   = 4'h0;
                    end
                end
                PBL_CHK_LOCK: begin
                    next_chk_lfsr = chk_step;
                    next_rx_cnt   = bump(next_rx_cnt, ctrl[`PBL_CONT_BIT]);
                    next_chk_run  = chk_match ? 4'h0 : 4'(chk_run + 4'h1);
                    if (!chk_match) begin
                        next_err_cnt = bump(next_err_cnt, ctrl[`PBL_CONT_BIT]);
                        if (chk_run == 4'(`PBL_LOSS_MISSES - 4'h1)) begin
                            next_chk_state = PBL_CHK_HUNT;
                            next_chk_run   = 4'h0;
                            next_sync_lost = 1'b1;
                        end
                    end
                end
                default: next_chk_state = PBL_CHK_HUNT;
            endcase
        end
    end

    // ---------------- MAC receive side and register reads ----------------
    logic       next_mac_rx_dv;
    logic [7:0] next_mac_rx_data;

    always_comb begin
        if (internal_loop) begin
            next_mac_rx_dv = chk_valid;
        end else if (is_reverse) begin
            next_mac_rx_dv = i_line_rx_dv && ctrl[`PBL_REV_MAC_BIT];
        end else begin
            next_mac_rx_dv = i_line_rx_dv;
        end
        next_mac_rx_data = next_mac_rx_dv ? chk_data : o_mac_rx_data;
        next_rdata = 16'h0000;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `PBL_CTRL_OFS:   next_rdata = ctrl;
                `PBL_STAT_OFS:   next_rdata = {13'h0000, gen_busy, sync_lost, locked};
                `PBL_RXCNT_OFS:  next_rdata = rx_cnt;
                `PBL_ERRCNT_OFS: next_rdata = err_cnt;
                default:         next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl          <= `PBL_CTRL_RST;
            o_loop_sel    <= 3'h0;
            o_reg_rdata   <= 16'h0000;
            gen_state     <= PBL_GEN_IDLE;
            gen_lfsr      <= `PBL_LFSR_SEED;
            gen_cnt       <= 11'd0;
            rh_valid      <= 1'b0;
            rh_data       <= 8'h00;
            chk_state     <= PBL_CHK_HUNT;
            chk_lfsr      <= `PBL_LFSR_SEED;
            chk_run       <= 4'h0;
            sync_lost     <= 1'b0;
            rx_cnt        <= 16'h0000;
            err_cnt       <= 16'h0000;
            o_mac_rx_dv   <= 1'b0;
            o_mac_rx_data <= 8'h00;
        end else begin
            ctrl          <= next_ctrl;
            o_loop_sel    <= next_loop_sel;
            o_reg_rdata   <= next_rdata;
            gen_state     <= next_gen_state;
            gen_lfsr      <= next_gen_lfsr;
            gen_cnt       <= next_gen_cnt;
            rh_valid      <= next_rh_valid;
            rh_data       <= next_rh_data;
            chk_state     <= next_chk_state;
            chk_lfsr      <= next_chk_lfsr;
            chk_run       <= next_chk_run;
            sync_lost     <= next_sync_lost;
            rx_cnt        <= next_rx_cnt;
            err_cnt       <= next_err_cnt;
            o_mac_rx_dv   <= next_mac_rx_dv;
            o_mac_rx_data <= next_mac_rx_data;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_last_miss;
        locked && ctrl[`PBL_CHK_EN_BIT] && chk_valid && !chk_match
            && chk_run == 4'(`PBL_LOSS_MISSES - 4'h1);
    endsequence
    sequence s_dropped;
        chk_state == PBL_CHK_HUNT && sync_lost;
    endsequence

    chk_ext_not_gig: assert property (i_gigabit |=> o_loop_sel != 3'h3)
        else $error("cable loop selected at gigabit");
    chk_rev_mac_off: assert property (is_reverse |-> !o_mac_tx_ready)
        else $error("MAC transmit accepted in reverse loop");
    chk_rev_rx_copy: assert property (is_reverse && !ctrl[`PBL_REV_MAC_BIT] |=> !o_mac_rx_dv)
        else $error("MAC receive driven in reverse loop");
    chk_lfsr_advance: assert property (gen_push |=> gen_lfsr == pbl_step8($past(gen_lfsr)))
        else $error("generator sequence broken");
    chk_lfsr_alive: assert property (gen_lfsr != 15'h0000 && chk_lfsr != 15'h0000 ||
        chk_state == PBL_CHK_HUNT)
        else $error("generator register stuck at zero");
    chk_pkt_end: assert property (gen_push && gen_cnt == 11'(pkt_len - 11'd1)
        |=> gen_state == PBL_GEN_GAP && gen_cnt == 11'd0)
        else $error("packet did not end at its length");
    chk_sync_loss: assert property (s_last_miss |=> s_dropped)
        else $error("sync loss not reported");
    chk_err_inc: assert property (locked && ctrl[`PBL_CHK_EN_BIT] && chk_valid && !chk_match
        && !rd_err && err_cnt != `PBL_CNT_MAX |=> err_cnt == $past(err_cnt) + 16'h0001)
        else $error("error byte not counted");
    chk_wrap_cont: assert property (locked && ctrl[`PBL_CHK_EN_BIT] && chk_valid
        && ctrl[`PBL_CONT_BIT] && rx_cnt == `PBL_CNT_MAX && !rd_rx |=> rx_cnt == 16'h0000)
        else $error("counter did not wrap");
    chk_hold_max: assert property (!ctrl[`PBL_CONT_BIT] && rx_cnt == `PBL_CNT_MAX && !rd_rx
        && !(i_reg_wr && i_reg_addr == `PBL_CTRL_OFS) |=> rx_cnt == `PBL_CNT_MAX)
        else $error("counter left its maximum");
    chk_count_unlocked: assert property (!locked && !rd_rx |=> $stable(rx_cnt))
        else $error("bytes counted while unlocked");
endmodule // pbl_bist

// >>> design/pbl_fifo.sv
`timescale 1ns/1ns
// words sit in a small array; the head word waits in an output register
module pbl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_in_ready;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    always_comb begin
        push           = i_in_valid && o_in_ready;
        pop            = (count != '0) && (!o_out_valid || i_out_ready);
        next_wr_ptr    = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr    = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count     = CW'(count + CW'(push) - CW'(pop));
        // ready reflects the fill of the coming cycle, so it is never optimistic
        next_in_ready  = next_count != CW'(DEPTH);
        next_out_valid = pop ? 1'b1 : (i_out_ready ? 1'b0 : o_out_valid);
        next_out_data  = pop ? mem[rd_ptr] : o_out_data;
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            o_in_ready  <= 1'b1;
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            o_in_ready  <= next_in_ready;
            o_out_valid <= next_out_valid;
            o_out_data  <= next_out_data;
        end
    end
endmodule // pbl_fifo

// >>> design/pbl_pkg.sv
package pbl_pkg;

    typedef logic [14:0] pbl_lfsr_t;

    typedef enum logic [2:0] {
        PBL_LOOP_NONE     = 3'h0,
        PBL_LOOP_DIGITAL  = 3'h1,
        PBL_LOOP_ANALOG   = 3'h2,
        PBL_LOOP_EXTERNAL = 3'h3,
        PBL_LOOP_REVERSE  = 3'h4
    } pbl_loop_e;

    typedef enum logic [2:0] {
        PBL_GEN_IDLE = 3'h1,
        PBL_GEN_PKT  = 3'h2,
        PBL_GEN_GAP  = 3'h4
    } pbl_gen_e;

    typedef enum logic [1:0] {
        PBL_CHK_HUNT = 2'h1,
        PBL_CHK_LOCK = 2'h2
    } pbl_chk_e;

    // eight steps of x^15 + x^14 + 1; the low byte is the byte on the wire
    function automatic pbl_lfsr_t pbl_step8(input pbl_lfsr_t s);
        pbl_lfsr_t t;
        t = s;
        for (int i = 0; i < 8; i++) begin
            t = {t[13:0], t[14] ^ t[13]};
        end
        return t;
    endfunction

endpackage

// >>> design/pbl_regs.svh
`ifndef PBL_REGS_SVH
`define PBL_REGS_SVH

// register offsets on the management port
`define PBL_CTRL_OFS      8'h16
`define PBL_STAT_OFS      8'h17
`define PBL_RXCNT_OFS     8'h71
`define PBL_ERRCNT_OFS    8'h72

// self_test_control fields
`define PBL_CTRL_RST      16'h0c00
`define PBL_GEN_EN_BIT    0
`define PBL_CHK_EN_BIT    1
`define PBL_LOOP_LSB      2
`define PBL_LOOP_MSB      4
`define PBL_REV_MAC_BIT   5
`define PBL_GAP_LSB       8
`define PBL_GAP_MSB       12
`define PBL_LONG_BIT      13
`define PBL_CONT_BIT      14

// self_test_status fields
`define PBL_LOCK_BIT      0
`define PBL_LOST_BIT      1
`define PBL_BUSY_BIT      2

// packet lengths in bytes and checker thresholds in bytes
`define PBL_SHORT_LEN     11'd64
`define PBL_LONG_LEN      11'd1518
`define PBL_LOCK_MATCHES  4'd4
`define PBL_LOSS_MISSES   4'd8
`define PBL_LFSR_SEED     15'h7fff
`define PBL_CNT_MAX       16'hffff

`endif

// >>> test/pbl_bist_tb.sv
`timescale 1ns/1ns
`include "pbl_regs.svh"
module pbl_bist_tb;
    logic        i_ref_clk, i_reset_n, i_reg_wr, i_reg_rd, i_gigabit;
    logic        mac_v, mac_l, loop, stall, flip, inj_dv;
    logic [7:0]  i_reg_addr, mac_d, inj_d;
    logic [15:0] i_reg_wdata, v;
    wire  [15:0] o_reg_rdata;
    wire         mac_rdy, mac_rx_dv, tx_v, tx_l, line_rdy, rx_dv;
    wire  [7:0]  mac_rx_d, tx_d, rx_d;
    wire  [2:0]  o_loop_sel;
    int          miscompares, n_compared, cycles, n;
    logic [8:0]  lq[$];
    logic [7:0]  mq[$];

    pbl_bist pbl_bist_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_gigabit(i_gigabit),
        .i_mac_tx_valid(mac_v), .i_mac_tx_data(mac_d), .i_mac_tx_last(mac_l),
        .o_mac_tx_ready(mac_rdy), .o_mac_rx_dv(mac_rx_dv), .o_mac_rx_data(mac_rx_d),
        .o_line_tx_valid(tx_v), .o_line_tx_data(tx_d), .o_line_tx_last(tx_l),
        .i_line_tx_ready(line_rdy), .i_line_rx_dv(rx_dv), .i_line_rx_data(rx_d),
        .o_loop_sel(o_loop_sel));
    pbl_line_model pbl_line_model_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_loop(loop), .i_stall(stall), .i_flip(flip), .i_inj_dv(inj_dv),
        .i_inj_data(inj_d), .i_tx_valid(tx_v), .i_tx_data(tx_d),
        .o_tx_ready(line_rdy), .o_rx_dv(rx_dv), .o_rx_data(rx_d));

    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // whole run needs about 2600 cycles
    always @(posedge i_ref_clk) begin
        if (tx_v && line_rdy) lq.push_back({tx_l, tx_d});
        if (mac_rx_dv) mq.push_back(mac_rx_d);
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd   <= 1'b0;
        #1 v = o_reg_rdata;
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge i_ref_clk);
    endtask

    // next byte from two previous bytes: they hold the whole 15-bit state
    function automatic logic [7:0] pred(input logic [7:0] a, input logic [7:0] b);
        logic [14:0] t;
        t = {a[6:0], b};
        for (int i = 0; i < 8; i++) t = {t[13:0], t[14] ^ t[13]};
        return t[7:0];
    endfunction

    task automatic t_reset();
        reg_rd(`PBL_CTRL_OFS); check(v, `PBL_CTRL_RST);
        reg_rd(`PBL_STAT_OFS); check(v, 16'h0000);
        reg_rd(`PBL_RXCNT_OFS); check(v, 16'h0000);
        reg_rd(`PBL_ERRCNT_OFS); check(v, 16'h0000);
        reg_wr(8'hfe, 16'he720);
        reg_rd(8'hfe); check(v, 16'h0000);
        reg_wr(`PBL_STAT_OFS, 16'hffff);
        reg_rd(`PBL_STAT_OFS); check(v, 16'h0000);
    endtask

    task automatic t_fifo();
        stall <= 1'b1;
        lq.delete();
        n = 0;
        mac_v <= 1'b1;
        mac_d <= 8'h00;
        repeat (14) begin
            @(posedge i_ref_clk);
            if (mac_rdy) n++;
            mac_d <= 8'(n);
        end
        mac_v <= 1'b0;
        check(16'(n >= 8 && n <= 9), 16'h0001);
        stall <= 1'b0;
        wait_cyc(20);
        check(16'(lq.size()), 16'(n));
        foreach (lq[i]) check({7'h00, lq[i]}, 16'(i));
    endtask

    task automatic t_loop_sel();
        reg_wr(`PBL_CTRL_OFS, 16'h0c0c);
        i_gigabit <= 1'b1;
        wait_cyc(2); check(16'(o_loop_sel), 16'h0000);
        i_gigabit <= 1'b0;
        wait_cyc(2); check(16'(o_loop_sel), 16'h0003);
        reg_wr(`PBL_CTRL_OFS, 16'h0c08);
        wait_cyc(2); check(16'(o_loop_sel), 16'h0002);
    endtask

    task automatic t_gen();
        loop <= 1'b1;
        lq.delete();
        reg_wr(`PBL_CTRL_OFS, 16'h0c0f);
        wait_cyc(400);
        reg_rd(`PBL_STAT_OFS);
        check(v[`PBL_LOCK_BIT], 1'b1);
        check(v[`PBL_BUSY_BIT], 1'b1);
        check(16'(lq.size() > 128), 16'h0001);
        check(lq[62][8], 1'b0);
        check(lq[63][8], 1'b1);
        for (int i = 2; i < 20; i++) check(lq[i][7:0], pred(lq[i-2][7:0], lq[i-1][7:0]));
        reg_rd(`PBL_ERRCNT_OFS); check(v, 16'h0000);
        reg_rd(`PBL_RXCNT_OFS); check(16'(v != 0), 16'h0001);
        for (int i = 0; i < 100 && !tx_v; i++) @(posedge i_ref_clk);
        flip <= 1'b1;
        @(posedge i_ref_clk);
        flip <= 1'b0;
        wait_cyc(20);
        reg_rd(`PBL_ERRCNT_OFS); check(v, 16'h0001);
        // eight returned bytes in a row corrupted: the checker must drop lock
        n = 0;
        flip <= 1'b1;
        while (n < 8) begin
            @(posedge i_ref_clk);
            if (tx_v) n++;
        end
        flip <= 1'b0;
        wait_cyc(100);
        reg_rd(`PBL_STAT_OFS);
        check(v[`PBL_LOST_BIT], 1'b1);
        check(v[`PBL_LOCK_BIT], 1'b1);
        reg_rd(`PBL_ERRCNT_OFS); check(v, 16'h0008);
        reg_rd(`PBL_STAT_OFS); check(v[`PBL_LOST_BIT], 1'b0);
        reg_wr(`PBL_CTRL_OFS, 16'h0c00);
        loop <= 1'b0;
        wait_cyc(200);
    endtask

    // digital loop, long packets: one 1518-byte frame loops back to the MAC with no errors
    task automatic t_int();
        lq.delete();
        mq.delete();
        reg_wr(`PBL_CTRL_OFS, 16'h6107);
        wait_cyc(1000);
        reg_wr(`PBL_CTRL_OFS, 16'h6106);
        wait_cyc(600);
        check(16'(o_loop_sel), 16'h0001);
        check(16'(lq.size()), 16'h05ee);
        check(lq[1516][8], 1'b0);
        check(lq[1517][8], 1'b1);
        check(16'(mq.size()), 16'h05ee);
        check(mq[700], lq[700][7:0]);
        reg_rd(`PBL_STAT_OFS); check(v, 16'h0001);
        reg_rd(`PBL_ERRCNT_OFS); check(v, 16'h0000);
    endtask

    task automatic inject(input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge i_ref_clk);
            inj_dv <= 1'b1;
            inj_d  <= 8'ha1 + 8'(i);
        end
        @(posedge i_ref_clk);
        inj_dv <= 1'b0;
        wait_cyc(10);
    endtask

    task automatic t_rev();
        reg_wr(`PBL_CTRL_OFS, 16'h0c30);
        lq.delete();
        mq.delete();
        mac_v <= 1'b1;
        mac_d <= 8'h5a;
        mac_l <= 1'b1;
        @(posedge i_ref_clk); check(mac_rdy, 1'b0);
        inject(3);
        check(16'(o_loop_sel), 16'h0004);
        check(16'(lq.size()), 16'h0003);
        foreach (lq[i]) check({7'h00, lq[i]}, {7'h00, i == 2, 8'ha1 + 8'(i)});
        check(16'(mq.size()), 16'h0003);
        foreach (mq[i]) check(mq[i], 8'ha1 + 8'(i));
        reg_wr(`PBL_CTRL_OFS, 16'h0c10);
        mq.delete();
        inject(1);
        check(16'(mq.size()), 16'h0000);
        mac_v <= 1'b0;
    endtask

    initial begin
        {i_reset_n, i_reg_wr, i_reg_rd, i_gigabit, mac_v, mac_l} = '0;
        {loop, stall, flip, inj_dv, i_reg_addr, mac_d, inj_d, i_reg_wdata} = '0;
        repeat (12) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_fifo();
        t_loop_sel();
        t_gen();
        t_int();
        t_rev();
        wrap_up();
    end
endmodule // pbl_bist_tb

// >>> test/pbl_line_model.sv
`timescale 1ns/1ns
// line-side partner: cable fixture or remote transceiver sending bytes
module pbl_line_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_loop,
    input  wire logic       i_stall,
    input  wire logic       i_flip,
    input  wire logic       i_inj_dv,
    input  wire logic [7:0] i_inj_data,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    output logic            o_tx_ready,
    output logic            o_rx_dv,
    output logic [7:0]      o_rx_data
);
    assign o_tx_ready = !i_stall;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_dv   <= 1'b0;
            o_rx_data <= 8'h00;
        end else if (i_loop && i_tx_valid && o_tx_ready) begin
            // fixture returns each sent byte, corrupted on command
            o_rx_dv   <= 1'b1;
            o_rx_data <= i_tx_data ^ {8{i_flip}};
        end else if (i_inj_dv) begin
            o_rx_dv   <= 1'b1;
            o_rx_data <= i_inj_data;
        end else begin
            // idle line never repeats its last byte
            o_rx_dv   <= 1'b0;
            o_rx_data <= ~o_rx_data;
        end
    end
endmodule // pbl_line_model
